// *** lo_vco_cfg_pkg.sv ***
package lo_vco_cfg_pkg;

    localparam int unsigned WORD_W        = 24;
    localparam int unsigned CTRL_W        = 3;
    localparam int unsigned BAND_W        = 6;
    localparam int unsigned AMP_W         = 6;
    localparam int unsigned CNT_W         = 5;

    // Control field values selecting each register
    localparam logic [2:0]  ADDR_LO_PATH  = 3'h5;
    localparam logic [2:0]  ADDR_VCO_CTRL = 3'h6;
    localparam logic [2:0]  ADDR_EXT_VCO  = 3'h7;

    localparam logic [23:0] LO_PATH_RST   = 24'h0000d5;
    localparam logic [23:0] VCO_CTRL_RST  = 24'h1e2106;
    localparam logic [23:0] EXT_VCO_RST   = 24'h000007;

    // LO path and modulator control fields
    localparam int unsigned LO_DRV_POS    = 3;
    localparam int unsigned LO_EXT_POS    = 4;
    localparam int unsigned LO_DIV_POS    = 5;
    localparam int unsigned MOD_OUT_POS   = 6;
    localparam int unsigned MOD_BIAS_POS  = 7;

    // VCO control fields
    localparam int unsigned BAND_LSB      = 3;
    localparam int unsigned BAND_SRC_POS  = 9;
    localparam int unsigned AMP_LSB       = 10;
    localparam int unsigned VCO_EN0_POS   = 17;
    localparam int unsigned VCO_EN1_POS   = 18;
    localparam int unsigned VCO_EN2_POS   = 19;
    localparam int unsigned CP_EN_POS     = 20;
    localparam int unsigned PWR_LSB       = 17;
    localparam int unsigned PWR_W         = 4;

    // External VCO field
    localparam int unsigned EXT_VCO_POS   = 22;

    localparam logic [4:0]  WORD_BITS     = 5'h18;

    typedef enum logic [1:0] {
        LO_PORT_OFF    = 2'b00,
        LO_PORT_IN_2X  = 2'b01,
        LO_PORT_OUT_1X = 2'b10,
        LO_PORT_OUT_2X = 2'b11
    } lo_port_mode_t;

    typedef struct packed {
        logic sclk;
        logic sdata;
        logic latch;
    } serial_pins_t;

    typedef struct packed {
        lo_port_mode_t lo_port_mode;
        logic          lo_port_drive;
        logic          lo_port_listen;
        logic          mod_lo_external;
        logic          mod_bias_en;
        logic          mod_out_en;
        logic [5:0]    vco_band;
        logic [5:0]    vco_amplitude;
        logic [2:0]    vco_core_en;
        logic          charge_pump_en;
        logic          synth_powered;
        logic          ext_vco_active;
    } cfg_out_t;

endpackage

// *** lo_path_vco_config_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module lo_path_vco_config_regs #(
    parameter int unsigned WORD_BITS_P = 24
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        ser_clk,
    input  wire logic                        ser_data,
    input  wire logic                        ser_latch,
    input  wire logic                        lo_port_select_pin,
    input  wire logic [5:0]                  cal_band,
    output lo_vco_cfg_pkg::cfg_out_t         cfg,
    output lo_vco_cfg_pkg::lo_port_mode_t    lo_port_mode,
    output logic                             lo_divide_select,
    output logic                             lo_external_input_select,
    output logic                             lo_output_drive_enable,
    output logic                             vco_band_source_select,
    output logic [23:0]                      lo_path_modulator_control,
    output logic [23:0]                      vco_control_enable,
    output logic [23:0]                      external_vco_enable
);

    initial begin
        if (WORD_BITS_P != lo_vco_cfg_pkg::WORD_W) begin
            $error("Serial word length must be 24 bits");
        end
    end

    typedef struct packed {
        lo_vco_cfg_pkg::serial_pins_t sync1;
        lo_vco_cfg_pkg::serial_pins_t sync2;
        lo_vco_cfg_pkg::serial_pins_t prev;
        logic                         sel1;
        logic                         sel2;
        logic [23:0]                  shift;
        logic [4:0]                   count;
        logic [23:0]                  lo_path;
        logic [23:0]                  vco_ctrl;
        logic [23:0]                  ext_vco;
        lo_vco_cfg_pkg::cfg_out_t     out;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    lo_vco_cfg_pkg::serial_pins_t pins_in;
    logic                         sclk_rise;
    logic                         latch_rise;
    logic                         word_full;
    logic [2:0]                   word_addr;
    logic                         sel_pin;
    logic                         div_bit;
    logic                         ext_bit;
    logic                         drv_bit;
    lo_vco_cfg_pkg::lo_port_mode_t mode;
    logic [5:0]                   manual_band;
    logic [5:0]                   amp;
    logic                         ext_vco_bit;

    assign pins_in.sclk  = ser_clk;
    assign pins_in.sdata = ser_data;
    assign pins_in.latch = ser_latch;

    // Edges taken from the second stage only
    assign sclk_rise  = state_r.sync2.sclk & ~state_r.prev.sclk;
    assign latch_rise = state_r.sync2.latch & ~state_r.prev.latch;
    assign word_full  = (state_r.count == lo_vco_cfg_pkg::WORD_BITS);
    assign word_addr  = state_r.shift[lo_vco_cfg_pkg::CTRL_W-1:0];

    assign sel_pin = state_r.sel2;
    assign div_bit = state_r.lo_path[lo_vco_cfg_pkg::LO_DIV_POS];
    assign ext_bit = state_r.lo_path[lo_vco_cfg_pkg::LO_EXT_POS];
    assign drv_bit = state_r.lo_path[lo_vco_cfg_pkg::LO_DRV_POS];

    assign manual_band = state_r.vco_ctrl[lo_vco_cfg_pkg::BAND_LSB +: lo_vco_cfg_pkg::BAND_W];
    assign amp         = state_r.vco_ctrl[lo_vco_cfg_pkg::AMP_LSB +: lo_vco_cfg_pkg::AMP_W];
    assign ext_vco_bit = state_r.ext_vco[lo_vco_cfg_pkg::EXT_VCO_POS];

    // Port function from select pin and the three path bits
    always_comb begin
        mode = lo_vco_cfg_pkg::LO_PORT_OFF;
        if (!sel_pin) begin
            if (drv_bit) begin
                mode = div_bit ? lo_vco_cfg_pkg::LO_PORT_OUT_2X
                               : lo_vco_cfg_pkg::LO_PORT_OUT_1X;
            end else if (ext_bit) begin
                mode = lo_vco_cfg_pkg::LO_PORT_IN_2X;
            end else begin
                mode = lo_vco_cfg_pkg::LO_PORT_OFF;
            end
        end else if (!ext_bit) begin
            mode = div_bit ? lo_vco_cfg_pkg::LO_PORT_OUT_2X
                           : lo_vco_cfg_pkg::LO_PORT_OUT_1X;
        end else begin
            // Combination absent from the port table; keep the port quiet
            mode = lo_vco_cfg_pkg::LO_PORT_OFF;
        end
    end

    always_comb begin
        state_nxt = state_r;

        state_nxt.sync1 = pins_in;
        state_nxt.sync2 = state_r.sync1;
        state_nxt.prev  = state_r.sync2;
        state_nxt.sel1  = lo_port_select_pin;
        state_nxt.sel2  = state_r.sel1;

        if (sclk_rise) begin
            state_nxt.shift = {state_r.shift[22:0], state_r.sync2.sdata};
            if (!word_full) begin
                state_nxt.count = state_r.count + 5'h01;
            end
        end

        if (latch_rise) begin
            state_nxt.count = 5'h00;
            if (word_full) begin
                unique case (word_addr)
                    lo_vco_cfg_pkg::ADDR_LO_PATH: begin
                        state_nxt.lo_path = state_r.shift;
                    end
                    lo_vco_cfg_pkg::ADDR_VCO_CTRL: begin
                        state_nxt.vco_ctrl = state_r.shift;
                    end
                    lo_vco_cfg_pkg::ADDR_EXT_VCO: begin
                        state_nxt.ext_vco = state_r.shift;
                    end
                    default: begin
                        // Registers of other blocks; nothing here changes
                    end
                endcase
            end
        end

        state_nxt.out.lo_port_mode   = mode;
        state_nxt.out.lo_port_drive  = (mode == lo_vco_cfg_pkg::LO_PORT_OUT_1X) ||
                                       (mode == lo_vco_cfg_pkg::LO_PORT_OUT_2X);
        // External double LO bypasses the synthesizer into the modulator
        state_nxt.out.mod_lo_external = (mode == lo_vco_cfg_pkg::LO_PORT_IN_2X);

        state_nxt.out.mod_bias_en = state_r.lo_path[lo_vco_cfg_pkg::MOD_BIAS_POS];
        // Output stage only runs when the whole modulator is biased
        state_nxt.out.mod_out_en  = state_r.lo_path[lo_vco_cfg_pkg::MOD_OUT_POS] &
                                    state_r.lo_path[lo_vco_cfg_pkg::MOD_BIAS_POS];

        state_nxt.out.vco_band = state_r.vco_ctrl[lo_vco_cfg_pkg::BAND_SRC_POS]
                               ? manual_band : cal_band;
        state_nxt.out.vco_amplitude = amp;

        state_nxt.out.ext_vco_active = ext_vco_bit && (amp == 6'h00);
        // Decided after the external VCO flag so both move in the same cycle
        state_nxt.out.lo_port_listen = (mode == lo_vco_cfg_pkg::LO_PORT_IN_2X) ||
                                       state_nxt.out.ext_vco_active;

        state_nxt.out.synth_powered =
            |state_r.vco_ctrl[lo_vco_cfg_pkg::PWR_LSB +: lo_vco_cfg_pkg::PWR_W];

        state_nxt.out.vco_core_en = {state_r.vco_ctrl[lo_vco_cfg_pkg::VCO_EN2_POS],
                                     state_r.vco_ctrl[lo_vco_cfg_pkg::VCO_EN1_POS],
                                     state_r.vco_ctrl[lo_vco_cfg_pkg::VCO_EN0_POS]};
        // Loop driven from outside means the internal cores stay off
        if (state_nxt.out.ext_vco_active || !state_nxt.out.synth_powered) begin
            state_nxt.out.vco_core_en = 3'h0;
        end

        state_nxt.out.charge_pump_en =
            state_r.vco_ctrl[lo_vco_cfg_pkg::CP_EN_POS] &
            state_nxt.out.synth_powered;

        if (rst) begin
            state_nxt = '0;
            state_nxt.lo_path  = lo_vco_cfg_pkg::LO_PATH_RST;
            state_nxt.vco_ctrl = lo_vco_cfg_pkg::VCO_CTRL_RST;
            state_nxt.ext_vco  = lo_vco_cfg_pkg::EXT_VCO_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        state_r <= state_nxt;
    end

    assign cfg                       = state_r.out;
    assign lo_port_mode              = state_r.out.lo_port_mode;
    assign lo_divide_select          = div_bit;
    assign lo_external_input_select  = ext_bit;
    assign lo_output_drive_enable    = drv_bit;
    assign vco_band_source_select    = state_r.vco_ctrl[lo_vco_cfg_pkg::BAND_SRC_POS];
    assign lo_path_modulator_control = state_r.lo_path;
    assign vco_control_enable        = state_r.vco_ctrl;
    assign external_vco_enable       = state_r.ext_vco;

endmodule

`default_nettype wire

// *** serial_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    input  wire logic core_clk,
    output var logic  ser_clk,
    output var logic  ser_data,
    output var logic  ser_latch
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_latch = 1'b0;
    end
    // MSB first; n above 24 sends leading extra bits, h sets the pace
    task automatic send(input logic [23:0] w, input int n, input int h);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge core_clk);
            ser_data <= w[i % 24];
            repeat (h) @(posedge core_clk);
            ser_clk <= 1'b1;
            repeat (h) @(posedge core_clk);
            ser_clk <= 1'b0;
        end
        repeat (h) @(posedge core_clk);
        ser_data <= ~w[0]; // No stale bit after release
        ser_latch <= 1'b1;
        repeat (6) @(posedge core_clk);
        ser_latch <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** lo_cfg_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module lo_cfg_checker (
    input wire logic                          core_clk,
    input wire logic                          rst,
    input wire logic                          ser_latch,
    input wire logic                          lo_port_select_pin,
    input wire logic [5:0]                    cal_band,
    input wire lo_vco_cfg_pkg::cfg_out_t      cfg,
    input wire lo_vco_cfg_pkg::lo_port_mode_t lo_port_mode,
    input wire logic                          lo_divide_select,
    input wire logic                          lo_external_input_select,
    input wire logic                          lo_output_drive_enable,
    input wire logic                          vco_band_source_select,
    input wire logic [23:0]                   lo_path_modulator_control,
    input wire logic [23:0]                   vco_control_enable,
    input wire logic [23:0]                   external_vco_enable
);
    logic [5:0] band;
    logic [5:0] amp;
    logic [3:0] pwr;
    assign band = vco_control_enable[8:3];
    assign amp = vco_control_enable[15:10];
    assign pwr = vco_control_enable[20:17];
    function automatic logic [1:0] mode_of(input logic s, input logic d, input logic e,
                                           input logic v);
        return (s ? !e : v) ? {1'b1, d} : {1'b0, !s & e};
    endfunction
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_RESET_VAL: assert property ($fell(rst) |->
        lo_path_modulator_control == 24'h0000d5 && vco_control_enable == 24'h1e2106)
        else $error("reset value wrong");
    AST_LO_BITS: assert property ({lo_divide_select, lo_external_input_select,
        lo_output_drive_enable} == lo_path_modulator_control[5:3]) else $error("lo bits wrong");
    AST_LO_MODE: assert property (($stable(lo_path_modulator_control) &&
        $stable(lo_port_select_pin)) [*6] |-> lo_port_mode == mode_of(lo_port_select_pin,
        lo_divide_select, lo_external_input_select, lo_output_drive_enable))
        else $error("lo port mode wrong");
    AST_BAND: assert property (!$past(rst) |-> cfg.vco_band ==
        ($past(vco_band_source_select) ? $past(band) : $past(cal_band))) else $error("band");
    AST_AMP: assert property (!$past(rst) |-> cfg.vco_amplitude == $past(amp))
        else $error("amplitude wrong");
    AST_SYNTH_OFF: assert property (!$past(rst) && $past(pwr) == 4'h0 |->
        !cfg.synth_powered && cfg.vco_core_en == 3'h0 && !cfg.charge_pump_en)
        else $error("synth not off");
    AST_EXT_VCO: assert property (!$past(rst) |-> cfg.ext_vco_active ==
        ($past(external_vco_enable[22]) && $past(amp) == 6'h0)) else $error("ext vco");
    AST_EXT_CORES: assert property (cfg.ext_vco_active |->
        cfg.vco_core_en == 3'h0 && cfg.lo_port_listen) else $error("cores on with ext vco");
    AST_MOD_EN: assert property (!$past(rst) |->
        cfg.mod_bias_en == $past(lo_path_modulator_control[7]) &&
        (!cfg.mod_out_en || cfg.mod_bias_en)) else $error("modulator enables wrong");
    AST_WRITE_TIME: assert property (!$past(rst) && ($changed(lo_path_modulator_control) ||
        $changed(vco_control_enable) || $changed(external_vco_enable)) |-> $past(ser_latch, 3))
        else $error("register changed without latch");
    cover property ($rose(cfg.ext_vco_active));
    cover property (lo_port_mode == lo_vco_cfg_pkg::LO_PORT_IN_2X);
    cover property (!cfg.synth_powered);
endmodule
bind lo_path_vco_config_regs lo_cfg_checker u_lo_cfg_checker (.*);
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                          core_clk = 1'b0;
    logic                          rst = 1'b1;
    logic                          lo_port_select_pin = 1'b0;
    logic [5:0]                    cal_band = 6'h15;
    logic                          ser_clk;
    logic                          ser_data;
    logic                          ser_latch;
    lo_vco_cfg_pkg::cfg_out_t      cfg;
    lo_vco_cfg_pkg::lo_port_mode_t lo_port_mode;
    logic [2:0]                    lo_bits;
    logic [23:0]                   lo_reg;
    logic [23:0]                   vco_reg;
    logic [23:0]                   ext_reg;
    int                            num_errors = 0;
    int                            total_checks = 0;
    int                            cycles = 0;
    always #2 core_clk = ~core_clk;
    serial_host u_serial_host (.core_clk(core_clk), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_latch(ser_latch));
    lo_path_vco_config_regs u_lo_path_vco_config_regs (.core_clk(core_clk), .rst(rst),
        .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch),
        .lo_port_select_pin(lo_port_select_pin), .cal_band(cal_band), .cfg(cfg),
        .lo_port_mode(lo_port_mode), .lo_divide_select(lo_bits[2]),
        .lo_external_input_select(lo_bits[1]), .lo_output_drive_enable(lo_bits[0]),
        .vco_band_source_select(), .lo_path_modulator_control(lo_reg),
        .vco_control_enable(vco_reg), .external_vco_enable(ext_reg));
    task automatic results();
        $display("Checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Decode lands four edges after the latch; eight leaves margin
    task automatic wr(input logic [23:0] w, input int n, input int h);
        u_serial_host.send(w, n, h);
        repeat (8) @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            results();
        end
    end
    task automatic t_reset();
        chk("lo_path", 24'h0000d5, lo_reg);
        chk("vco_ctrl", 24'h1e2106, vco_reg);
        chk("amplitude", 24'd8, 24'(cfg.vco_amplitude));
        chk("charge_pump", 24'd1, 24'(cfg.charge_pump_en));
        chk("mod_en", 24'd3, 24'({cfg.mod_bias_en, cfg.mod_out_en}));
    endtask
    task automatic t_lo();
        logic [1:0] m;
        for (int b = 0; b < 8; b++) begin
            wr({16'h0, 2'b01, b[2:0], 3'h5}, 24, 4);
            chk("lo_bits", 24'(b[2:0]), 24'(lo_bits));
            for (int s = 0; s < 2; s++) begin
                lo_port_select_pin <= s[0];
                repeat (8) @(posedge core_clk);
                m = (s[0] ? !b[1] : b[0]) ? {1'b1, b[2]} : {1'b0, !s[0] & b[1]};
                chk("lo_mode", 24'(m), 24'(lo_port_mode));
                chk("ext_lo", 24'(m == 2'b01), 24'(cfg.mod_lo_external));
                chk("drive", 24'(m[1]), 24'(cfg.lo_port_drive));
                chk("listen", 24'(m == 2'b01), 24'(cfg.lo_port_listen));
            end
        end
        chk("mod_en", 24'd0, 24'({cfg.mod_bias_en, cfg.mod_out_en}));
    endtask
    task automatic t_vco();
        logic [23:0] w;
        w = {3'h0, 4'hb, 1'b0, 6'h3f, 1'b1, 6'h2a, 3'h6};
        wr(w, 24, 4);
        chk("vco_ctrl", w, vco_reg);
        chk("band", 24'h2a, 24'(cfg.vco_band));
        chk("amplitude", 24'h3f, 24'(cfg.vco_amplitude));
        chk("cores", 24'h3, 24'(cfg.vco_core_en));
        w[9] = 1'b0;
        w[15:10] = 6'h0;
        wr(w, 24, 8);
        chk("band", 24'h15, 24'(cfg.vco_band));
        wr(24'h400007, 24, 4);
        chk("ext_reg", 24'h400007, ext_reg);
        chk("ext_vco", 24'h8, 24'({cfg.ext_vco_active, cfg.vco_core_en}));
        chk("ext_listen", 24'h1, 24'(cfg.lo_port_listen));
        w[20:17] = 4'h0;
        wr(w, 24, 4);
        chk("synth", 24'h0, 24'({cfg.synth_powered, cfg.charge_pump_en}));
    endtask
    task automatic t_refuse();
        wr(24'h0000c5, 20, 4);
        chk("short_word", 24'h00007d, lo_reg);
        wr(24'hfffffb, 24, 4);
        chk("bad_addr", 24'h00007d, lo_reg);
        wr(24'h0000cd, 25, 4);
        chk("long_word", 24'h0000cd, lo_reg);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        t_reset();
        t_lo();
        t_vco();
        t_refuse();
        results();
    end
endmodule
`default_nettype wire
